// [src/cdsp_frame_gen.sv]
// Conversion period counter: one start pulse per period of shift clocks
// Assumes period is never below the minimum kept by the register logic
`timescale 1ns/1ps
module cdsp_frame_gen
    import cdsp_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    cdsp_frame_if.gen fr
);

    logic [W-1:0] cnt_q;
    logic         start_q;

    if (W < 10 || W > 31) begin : g_chk
        $error("cdsp_frame_gen: W must be 10 to 31");
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q   <= '0;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (fr.tick) begin
                if (cnt_q >= fr.period - W'(1)) begin
                    cnt_q   <= '0;
                    start_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + W'(1);
                end
            end
        end
    end

    assign fr.start = start_q;

endmodule

// [src/cdsp_frame_if.sv]
// Frame timing carrier between the port and a conversion period counter
// Assumes tick is one clk_sys cycle per shift-clock period
`timescale 1ns/1ps
interface cdsp_frame_if #(parameter int W = 16);
    logic         tick;
    logic [W-1:0] period;
    logic         start;

    modport gen  (input tick, input period, output start);
    modport user (output tick, output period, input start);
endinterface

// [src/cdsp_pkg.sv]
// Types shared by the codec serial port modules
// Assumes cdsp_regs.svh carries the numeric constants
package cdsp_pkg;

    // Transfer kind of the transmit engine
    typedef enum logic [2:0] {
        CDSP_IDLE = 3'b001,
        CDSP_PRIM = 3'b010,
        CDSP_SEC  = 3'b100
    } cdsp_xfer_e;

    typedef logic [4:0] cdsp_pos_t;

endpackage

// [src/cdsp_regs.svh]
// Register offsets, field positions, reset values and timing counts
// Assumes a 32-bit register port with byte addresses and a 50 MHz clk_sys
`ifndef CDSP_REGS_SVH
`define CDSP_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CDSP_ADDR_CTRL      8'h00
`define CDSP_ADDR_TX_PERIOD 8'h04
`define CDSP_ADDR_RX_PERIOD 8'h08
`define CDSP_ADDR_ADC_DATA  8'h0C
`define CDSP_ADDR_DAC_DATA  8'h10
`define CDSP_ADDR_STATUS    8'h14

// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define CDSP_CTRL_RST       12'h02E4
`define CDSP_CTRL_AUX_BIT   4
`define CDSP_CTRL_SYNC_BIT  5
`define CDSP_CTRL_TEN_BIT   10
`define CDSP_CTRL_ELEVEN_BIT 11
`define CDSP_SEC_TAG        2'h3
`define CDSP_PERIOD_RST     16'h030D

// ----------------------------------------
// Timing
// ----------------------------------------
`define CDSP_CLK_HZ         50000000
`define CDSP_SCLK_DIV       4
`define CDSP_MAX_RATE_SPS   25000
`define CDSP_MIN_PERIOD_SCLK \
    ((`CDSP_CLK_HZ + `CDSP_SCLK_DIV * `CDSP_MAX_RATE_SPS - 1) / \
     (`CDSP_SCLK_DIV * `CDSP_MAX_RATE_SPS))
`define CDSP_WORD_LOW       16
`define CDSP_WORD_LAST      19
`define CDSP_BYTE_LOW       8
`define CDSP_BYTE_GAP       12
`define CDSP_BYTE_END       20
`define CDSP_BYTE_LAST      23

`endif

// [src/cdsp_serial_port.sv]
// Serial data port and mode logic of a wide-band codec facing a DSP port
// Assumes clk_sys is the master clock; pins are outside its domain
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "cdsp_regs.svh"

module cdsp_serial_port
    import cdsp_pkg::*;
#(
    parameter int PERIOD_W = 16
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        serial_in_line,
    output logic             serial_out_line,
    output logic             shift_clock,
    output logic             tx_frame_strobe_n,
    output logic             rx_frame_strobe_n,
    output logic             end_of_tx_strobe_n,
    output logic             end_of_rx_strobe_n,
    output logic             secondary_frame_strobe_n,
    output logic             secondary_frame_strobe_oe,
    input  wire logic        word_byte_sel_in,
    input  wire logic        aux_data_or_strap_pin,
    input  wire logic        strap_tied_neg,
    output logic             gp_out_bit_ten,
    output logic             gp_out_bit_eleven,
    output logic             aux_input_sel
);

    if (PERIOD_W < 10 || PERIOD_W > 31) begin : g_chk
        $error("cdsp_serial_port: PERIOD_W must be 10 to 31");
    end

    localparam logic [PERIOD_W-1:0] MIN_PER = PERIOD_W'(`CDSP_MIN_PERIOD_SCLK);
    localparam logic [PERIOD_W-1:0] RST_PER = PERIOD_W'(`CDSP_PERIOD_RST);

    // ----------------------------------------
    // Frame shape helpers
    // ----------------------------------------
    function automatic logic strobe_low(input logic by, input cdsp_pos_t p);
        if (by) begin
            strobe_low = (p < 5'(`CDSP_BYTE_LOW)) ||
                         (p >= 5'(`CDSP_BYTE_GAP) && p < 5'(`CDSP_BYTE_END));
        end else begin
            strobe_low = p < 5'(`CDSP_WORD_LOW);
        end
    endfunction

    function automatic logic eod_low(input logic by, input cdsp_pos_t p);
        if (by) begin
            eod_low = p >= 5'(`CDSP_BYTE_LOW) && p < 5'(`CDSP_BYTE_END);
        end else begin
            eod_low = p == 5'(`CDSP_WORD_LOW);
        end
    endfunction

    function automatic cdsp_pos_t last_pos(input logic by);
        last_pos = by ? 5'(`CDSP_BYTE_LAST) : 5'(`CDSP_WORD_LAST);
    endfunction

    // Bit shown at a position; the next byte's MSB leads its strobe
    function automatic logic [3:0] bit_idx(input logic by, input cdsp_pos_t p);
        if (!by) begin
            bit_idx = (p < 5'(`CDSP_WORD_LOW)) ? 4'(5'd15 - p) : 4'h0;
        end else if (p < 5'(`CDSP_BYTE_LOW)) begin
            bit_idx = 4'(5'd15 - p);
        end else if (p < 5'(`CDSP_BYTE_GAP)) begin
            bit_idx = 4'h7;
        end else if (p < 5'(`CDSP_BYTE_END)) begin
            bit_idx = 4'(5'd19 - p);
        end else begin
            bit_idx = 4'h0;
        end
    endfunction

    function automatic logic [PERIOD_W-1:0] clamp_per(input logic [31:0] v);
        if (|v[31:PERIOD_W]) begin
            clamp_per = '1;
        end else if (v[PERIOD_W-1:0] < MIN_PER) begin
            clamp_per = MIN_PER;
        end else begin
            clamp_per = v[PERIOD_W-1:0];
        end
    endfunction

    // ----------------------------------------
    // Shift clock and pin synchronisers
    // ----------------------------------------
    logic [1:0] div_q;
    logic       sclk_q;
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic       rise_w;
    logic       samp_w;
    logic       dx_s;
    logic       aux_s;
    logic       dual_w;
    logic       byte_w;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            div_q  <= 2'h0;
            sclk_q <= 1'b1;
        end else begin
            div_q  <= div_q + 2'h1;
            sclk_q <= (div_q == 2'h3) || (div_q == 2'h0);
        end
    end

    assign rise_w = div_q == 2'h3;
    assign samp_w = div_q == 2'h2;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= {word_byte_sel_in, strap_tied_neg,
                         aux_data_or_strap_pin, serial_in_line};
            sync2_q <= sync1_q;
        end
    end

    assign dx_s   = sync2_q[0];
    assign aux_s  = sync2_q[1];
    assign dual_w = !sync2_q[2];
    assign byte_w = !dual_w && !sync2_q[3];

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [11:0]         ctrl_q;
    logic [PERIOD_W-1:0] tx_per_q;
    logic [PERIOD_W-1:0] rx_per_q;
    logic [13:0]         adc_q;
    logic [15:0]         dac_q;
    logic                dac_new_q;
    logic [31:0]         rdata_q;
    logic                oe_q;
    logic                dac_load_w;
    logic                ctrl_load_w;
    logic                sync_w;
    cdsp_xfer_e          tx_st_q;
    logic [15:0]         tx_sreg_q;
    logic                rx_busy_q;

    assign sync_w = ctrl_q[`CDSP_CTRL_SYNC_BIT];

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= `CDSP_CTRL_RST;
        end else if (ctrl_load_w) begin
            ctrl_q <= {tx_sreg_q[11:2], 2'h0};
        end else if (reg_wr && reg_addr == `CDSP_ADDR_CTRL) begin
            ctrl_q <= {reg_wdata[11:2], 2'h0};
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tx_per_q <= RST_PER;
            rx_per_q <= RST_PER;
            adc_q    <= 14'h0000;
        end else if (reg_wr) begin
            if (reg_addr == `CDSP_ADDR_TX_PERIOD) begin
                tx_per_q <= clamp_per(reg_wdata);
            end
            if (reg_addr == `CDSP_ADDR_RX_PERIOD) begin
                rx_per_q <= clamp_per(reg_wdata);
            end
            if (reg_addr == `CDSP_ADDR_ADC_DATA) begin
                adc_q <= reg_wdata[13:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dac_q     <= 16'h0000;
            dac_new_q <= 1'b0;
        end else begin
            if (dac_load_w) begin
                dac_q <= tx_sreg_q;
            end
            // A word landing with the read keeps its flag
            dac_new_q <= dac_load_w ||
                         (dac_new_q && !(reg_rd && reg_addr == `CDSP_ADDR_DAC_DATA));
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `CDSP_ADDR_CTRL:      rdata_q <= {20'h0_0000, ctrl_q};
                `CDSP_ADDR_TX_PERIOD: rdata_q <= 32'(tx_per_q);
                `CDSP_ADDR_RX_PERIOD: rdata_q <= 32'(rx_per_q);
                `CDSP_ADDR_ADC_DATA:  rdata_q <= {18'h0_0000, adc_q};
                `CDSP_ADDR_DAC_DATA:  rdata_q <= {16'h0000, dac_q};
                `CDSP_ADDR_STATUS:    rdata_q <= {27'h000_0000, byte_w, dual_w,
                                                  tx_st_q != CDSP_IDLE,
                                                  rx_busy_q, dac_new_q};
                default:              rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // Conversion period counters
    // ----------------------------------------
    cdsp_frame_if #(.W(PERIOD_W)) tx_if ();
    cdsp_frame_if #(.W(PERIOD_W)) rx_if ();

    assign tx_if.tick   = rise_w;
    assign tx_if.period = tx_per_q;
    assign rx_if.tick   = rise_w;
    assign rx_if.period = rx_per_q;

    cdsp_frame_gen #(.W(PERIOD_W)) u_tx_gen (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .fr      (tx_if.gen)
    );

    cdsp_frame_gen #(.W(PERIOD_W)) u_rx_gen (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .fr      (rx_if.gen)
    );

    // ----------------------------------------
    // Frame scheduling
    // ----------------------------------------
    logic tx_pend_q;
    logic rx_pend_q;
    logic sec_pend_q;
    logic rx_start_w;
    logic tx_take_w;
    logic rx_take_w;
    logic sec_take_w;
    logic sec_req_w;
    cdsp_pos_t tx_pos_q;
    logic tx_end_w;

    assign rx_start_w = sync_w ? tx_if.start : rx_if.start;
    assign tx_take_w  = rise_w && tx_pend_q && tx_st_q == CDSP_IDLE && !sec_pend_q;
    assign sec_take_w = rise_w && sec_pend_q && tx_st_q == CDSP_IDLE && !rx_busy_q;
    assign rx_take_w  = rise_w && rx_pend_q && !rx_busy_q && tx_st_q != CDSP_SEC
                        && !sec_take_w;
    assign tx_end_w   = rise_w && tx_st_q != CDSP_IDLE && tx_pos_q == last_pos(byte_w);
    assign sec_req_w  = tx_end_w && tx_st_q == CDSP_PRIM
                        && tx_sreg_q[1:0] == `CDSP_SEC_TAG;
    assign dac_load_w = tx_end_w && tx_st_q == CDSP_PRIM;
    assign ctrl_load_w = tx_end_w && tx_st_q == CDSP_SEC
                         && tx_sreg_q[1:0] == `CDSP_SEC_TAG;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tx_pend_q  <= 1'b0;
            rx_pend_q  <= 1'b0;
            sec_pend_q <= 1'b0;
        end else begin
            tx_pend_q  <= tx_if.start || (tx_pend_q && !tx_take_w);
            rx_pend_q  <= rx_start_w || (rx_pend_q && !rx_take_w);
            sec_pend_q <= sec_req_w || (sec_pend_q && !sec_take_w);
        end
    end

    // ----------------------------------------
    // Transmit engine (DSP to codec)
    // ----------------------------------------
    logic fsx_n_q;
    logic fsd_n_q;
    logic end_of_tx_strobe_n_n_q;
    logic tx_low_w;

    assign tx_low_w = strobe_low(byte_w, tx_pos_q);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tx_st_q  <= CDSP_IDLE;
            tx_pos_q <= 5'h00;
        end else if (tx_take_w) begin
            tx_st_q  <= CDSP_PRIM;
            tx_pos_q <= 5'h00;
        end else if (sec_take_w) begin
            tx_st_q  <= CDSP_SEC;
            tx_pos_q <= 5'h00;
        end else if (tx_end_w) begin
            tx_st_q <= CDSP_IDLE;
        end else if (rise_w && tx_st_q != CDSP_IDLE) begin
            tx_pos_q <= tx_pos_q + 5'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fsx_n_q  <= 1'b1;
            fsd_n_q  <= 1'b1;
            end_of_tx_strobe_n_n_q <= 1'b1;
        end else if (rise_w) begin
            fsx_n_q  <= !(tx_st_q != CDSP_IDLE && tx_low_w);
            fsd_n_q  <= !(dual_w && tx_st_q == CDSP_SEC && tx_low_w);
            end_of_tx_strobe_n_n_q <= !(!dual_w && tx_st_q != CDSP_IDLE
                          && eod_low(byte_w, tx_pos_q));
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tx_sreg_q <= 16'h0000;
        end else if (samp_w && !fsx_n_q) begin
            tx_sreg_q <= {tx_sreg_q[14:0], dx_s};
        end
    end

    // ----------------------------------------
    // Receive engine (codec to DSP)
    // ----------------------------------------
    cdsp_pos_t   rx_pos_q;
    logic [15:0] rx_word_q;
    logic        fsr_n_q;
    logic        end_of_rx_strobe_n_n_q;
    logic        dr_q;
    logic        rx_end_w;

    assign rx_end_w = rise_w && rx_busy_q && rx_pos_q == last_pos(byte_w);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rx_busy_q <= 1'b0;
            rx_pos_q  <= 5'h00;
            rx_word_q <= 16'h0000;
        end else if (rx_take_w) begin
            rx_busy_q <= 1'b1;
            rx_pos_q  <= 5'h00;
            rx_word_q <= {adc_q, 2'h0};
        end else if (rx_end_w) begin
            rx_busy_q <= 1'b0;
        end else if (rise_w && rx_busy_q) begin
            rx_pos_q <= rx_pos_q + 5'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fsr_n_q  <= 1'b1;
            end_of_rx_strobe_n_n_q <= 1'b1;
        end else if (rise_w) begin
            fsr_n_q  <= !(rx_busy_q && strobe_low(byte_w, rx_pos_q));
            end_of_rx_strobe_n_n_q <= !(!dual_w && rx_busy_q
                          && eod_low(byte_w, rx_pos_q));
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dr_q <= 1'b0;
        end else if (rise_w) begin
            if (dual_w && tx_st_q == CDSP_SEC && tx_low_w) begin
                dr_q <= aux_s;
            end else if (rx_take_w) begin
                dr_q <= adc_q[13];
            end else if (rx_busy_q) begin
                dr_q <= rx_word_q[bit_idx(byte_w, rx_pos_q)];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= dual_w;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata                 = rdata_q;
    assign serial_out_line           = dr_q;
    assign shift_clock               = sclk_q;
    assign tx_frame_strobe_n         = fsx_n_q;
    assign rx_frame_strobe_n         = fsr_n_q;
    assign end_of_tx_strobe_n        = end_of_tx_strobe_n_n_q;
    assign end_of_rx_strobe_n        = end_of_rx_strobe_n_n_q;
    assign secondary_frame_strobe_n  = fsd_n_q;
    assign secondary_frame_strobe_oe = oe_q;
    assign gp_out_bit_ten            = ctrl_q[`CDSP_CTRL_TEN_BIT];
    assign gp_out_bit_eleven         = ctrl_q[`CDSP_CTRL_ELEVEN_BIT];
    assign aux_input_sel             = ctrl_q[`CDSP_CTRL_AUX_BIT];

endmodule

// [verif/cdsp_dsp_model.sv]
// Behavioural DSP serial port on the far side of the codec pins
// Assumes strobes settle within 1 ns of a shift-clock rise
`timescale 1ns/1ps
module cdsp_dsp_model (
    input  wire logic        shift_clock,
    input  wire logic        tx_frame_strobe_n,
    input  wire logic        rx_frame_strobe_n,
    input  wire logic        secondary_frame_strobe_n,
    input  wire logic        serial_out_line,
    input  wire logic [15:0] tx_word,
    output logic             serial_in_line = 1'b0,
    output logic [15:0]      rx_word = 16'h0000,
    output logic             rx_sec = 1'b0,
    output int               rx_cnt = 0
);
    int          tx_i = 15;
    int          rx_i = 15;
    int          idle = 0;
    logic [15:0] sh = 16'h0000;
    // Long idle realigns both bit counters
    always @(posedge shift_clock) begin
        #1;
        if (tx_frame_strobe_n && rx_frame_strobe_n && secondary_frame_strobe_n)
            idle = idle + 1;
        else
            idle = 0;
        if (idle > 5) begin
            tx_i = 15;
            rx_i = 15;
        end
        if (!tx_frame_strobe_n) begin
            serial_in_line <= tx_word[tx_i];
            tx_i = (tx_i == 0) ? 15 : tx_i - 1;
        end else begin
            serial_in_line <= ~serial_in_line;
        end
    end
    always @(negedge shift_clock) begin
        if (!rx_frame_strobe_n || !secondary_frame_strobe_n) begin
            sh = {sh[14:0], serial_out_line};
            if (rx_i == 0) begin
                rx_word <= sh;
                rx_sec <= !secondary_frame_strobe_n;
                rx_cnt <= rx_cnt + 1;
            end
            rx_i = (rx_i == 0) ? 15 : rx_i - 1;
        end
    end
endmodule

// [verif/cdsp_port_sva.sv]
// Checker for the codec serial port pins, bound to the top module
// Assumes one clk_sys domain; mode pins only change under reset
`timescale 1ns/1ps
`include "cdsp_regs.svh"
module cdsp_port_sva (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        shift_clock,
    input wire logic        tx_frame_strobe_n,
    input wire logic        rx_frame_strobe_n,
    input wire logic        end_of_tx_strobe_n,
    input wire logic        end_of_rx_strobe_n,
    input wire logic        secondary_frame_strobe_n,
    input wire logic        word_byte_sel_in,
    input wire logic        strap_tied_neg,
    input wire logic        gp_out_bit_ten,
    input wire logic        gp_out_bit_eleven,
    input wire logic        aux_input_sel
);
    logic [7:0] fsd_q, fsr_q;
    logic       word_m, byte_m;
    assign word_m = strap_tied_neg & word_byte_sel_in;
    assign byte_m = strap_tied_neg & ~word_byte_sel_in;
    // Low time of the secondary and receive frame strobes in clk_sys cycles
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fsd_q <= 8'h00;
            fsr_q <= 8'h00;
        end else begin
            fsd_q <= secondary_frame_strobe_n ? 8'h00 : fsd_q + 8'h01;
            fsr_q <= rx_frame_strobe_n ? 8'h00 : fsr_q + 8'h01;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence s_sclk;
        shift_clock ##1 !shift_clock [*2] ##1 shift_clock;
    endsequence
    sequence s_eod(logic e);
        !e [*4] ##1 e;
    endsequence
    chk_sclk_quarter:
        assert property ($rose(shift_clock) |=> s_sclk) else $error("shift clock ratio");
    chk_gp_follow:
        assert property (reg_wr && reg_addr == `CDSP_ADDR_CTRL |=> gp_out_bit_ten ==
            $past(reg_wdata[10]) && gp_out_bit_eleven == $past(reg_wdata[11]))
            else $error("gp pins lag control bits");
    chk_reset_bits:
        assert property ($rose(rst_b) |-> !gp_out_bit_ten && !gp_out_bit_eleven
            && !aux_input_sel) else $error("control bits not cleared");
    chk_fsd_primary:
        assert property (!rx_frame_strobe_n |-> secondary_frame_strobe_n)
            else $error("secondary strobe low in primary");
    chk_fsd_copy:
        assert property (!secondary_frame_strobe_n |-> !tx_frame_strobe_n)
            else $error("secondary strobe without transmit strobe");
    chk_fsd_release:
        assert property ($rose(tx_frame_strobe_n) && !$past(secondary_frame_strobe_n)
            |-> secondary_frame_strobe_n) else $error("secondary strobe stays low");
    chk_fsd_len:
        assert property ($rose(secondary_frame_strobe_n) |-> fsd_q == 8'h40)
            else $error("secondary strobe length");
    chk_fsr_len:
        assert property ($rose(rx_frame_strobe_n) |-> fsr_q == (byte_m ? 8'h20 : 8'h40))
            else $error("receive strobe length");
    chk_end_of_tx_strobe_n_word:
        assert property ($rose(tx_frame_strobe_n) && word_m |-> s_eod(end_of_tx_strobe_n))
            else $error("end of transmit pulse");
    chk_end_of_rx_strobe_n_word:
        assert property ($rose(rx_frame_strobe_n) && word_m |-> s_eod(end_of_rx_strobe_n))
            else $error("end of receive pulse");
    chk_end_of_tx_strobe_n_byte:
        assert property ($fell(end_of_tx_strobe_n) && byte_m |-> $rose(tx_frame_strobe_n))
            else $error("end of transmit byte level");
    chk_end_of_rx_strobe_n_byte:
        assert property ($rose(end_of_rx_strobe_n) && byte_m |-> $rose(rx_frame_strobe_n))
            else $error("end of receive byte level");
endmodule

bind cdsp_serial_port cdsp_port_sva u_cdsp_port_sva (
    .clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .shift_clock,
    .tx_frame_strobe_n, .rx_frame_strobe_n, .end_of_tx_strobe_n,
    .end_of_rx_strobe_n, .secondary_frame_strobe_n, .word_byte_sel_in,
    .strap_tied_neg, .gp_out_bit_ten, .gp_out_bit_eleven, .aux_input_sel
);

// [verif/test_codec_dsp_serial_port_modes.sv]
// Self-checking bench for the codec serial port and its mode pins
// Assumes the DSP model and the bound checker are compiled first
`timescale 1ns/1ps
`include "cdsp_regs.svh"
module test_codec_dsp_serial_port_modes;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        wb_pin = 1'b1;
    logic        aux_data_or_strap_pin = 1'b0;
    logic        strap_tied_neg = 1'b1;
    logic [15:0] tx_word = 16'h0000;
    logic [31:0] reg_rdata;
    logic        serial_in_line, serial_out_line, shift_clock, tx_frame_strobe_n;
    logic        rx_frame_strobe_n, end_of_tx_strobe_n, end_of_rx_strobe_n;
    logic        secondary_frame_strobe_n, secondary_frame_strobe_oe, word_byte_sel_in;
    logic        gp_out_bit_ten, gp_out_bit_eleven, aux_input_sel, rx_sec;
    logic [15:0] rx_word;
    int          rx_cnt;
    int          bad_count = 0;
    int          comparisons = 0;
    integer      seed = 32'hdc96_9255;
    logic [15:0] exp_q[$];
    // Shared strobe and mode pin level
    assign word_byte_sel_in = secondary_frame_strobe_oe ? secondary_frame_strobe_n : wb_pin;
    cdsp_serial_port #(.PERIOD_W(16)) u_cdsp_serial_port (
        .clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .serial_in_line, .serial_out_line, .shift_clock, .tx_frame_strobe_n,
        .rx_frame_strobe_n, .end_of_tx_strobe_n, .end_of_rx_strobe_n,
        .secondary_frame_strobe_n, .secondary_frame_strobe_oe, .word_byte_sel_in,
        .aux_data_or_strap_pin, .strap_tied_neg, .gp_out_bit_ten, .gp_out_bit_eleven,
        .aux_input_sel
    );
    cdsp_dsp_model u_cdsp_dsp_model (
        .shift_clock, .tx_frame_strobe_n, .rx_frame_strobe_n,
        .secondary_frame_strobe_n, .serial_out_line, .tx_word, .serial_in_line,
        .rx_word, .rx_sec, .rx_cnt
    );
    initial forever #10 clk_sys = ~clk_sys;
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys) reg_wr <= 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk(reg_rdata, exp);
    endtask
    task automatic do_reset(input logic sn, input logic wb);
        @(posedge clk_sys);
        rst_b <= 1'b0;
        strap_tied_neg <= sn;
        wb_pin <= wb;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
    endtask
    task automatic wait_rx(input int n, input logic sec);
        int base;
        base = rx_cnt;
        for (int i = 0; i < 30000 && (rx_cnt < base + n || rx_sec !== sec); i++)
            @(posedge clk_sys);
        if (rx_cnt < base + n || rx_sec !== sec) begin
            bad_count++;
            end_of_test();
        end
    endtask
    initial begin
        logic [13:0] adc;
        logic [15:0] dac;
        do_reset(1'b1, 1'b1);
        rd(`CDSP_ADDR_CTRL, 32'h0000_02E4);
        chk({29'h0, aux_input_sel, gp_out_bit_eleven, gp_out_bit_ten}, 32'h0);
        rd(`CDSP_ADDR_RX_PERIOD, 32'h0000_030D);
        rd(8'h18, 32'h0000_0000);
        wr(`CDSP_ADDR_TX_PERIOD, 32'h0000_000A);
        rd(`CDSP_ADDR_TX_PERIOD, 32'h0000_01F4);
        // Word and byte formats, each synchronous and asynchronous
        for (int m = 0; m < 4; m++) begin
            do_reset(1'b1, m[0]);
            adc = 14'($random(seed));
            dac = 16'($random(seed)) & 16'hFFFC;
            tx_word <= dac;
            wr(`CDSP_ADDR_TX_PERIOD, 32'h0000_01F4);
            wr(`CDSP_ADDR_RX_PERIOD, 32'h0000_01F4);
            wr(`CDSP_ADDR_CTRL, m[1] ? 32'h0000_02C4 : 32'h0000_02E4);
            wr(`CDSP_ADDR_ADC_DATA, {18'h0, adc});
            chk({31'h0, secondary_frame_strobe_oe}, 32'h0);
            exp_q.push_back({adc, 2'b00});
            wait_rx(2, 1'b0);
            chk({16'h0, rx_word}, {16'h0, exp_q.pop_front()});
            rd(`CDSP_ADDR_DAC_DATA, {16'h0, dac});
        end
        // Dual-word mode: pins, secondary frame and control load from the DSP
        do_reset(1'b0, 1'b1);
        adc = 14'($random(seed));
        aux_data_or_strap_pin <= 1'b1;
        tx_word <= 16'h0C27;
        wr(`CDSP_ADDR_TX_PERIOD, 32'h0000_01F4);
        wr(`CDSP_ADDR_CTRL, 32'h0000_0EF4);
        chk({28'h0, secondary_frame_strobe_oe, aux_input_sel, gp_out_bit_eleven,
             gp_out_bit_ten}, 32'hF);
        wr(`CDSP_ADDR_ADC_DATA, {18'h0, adc});
        wait_rx(1, 1'b1);
        tx_word <= 16'h1234;
        chk({16'h0, rx_word}, 32'h0000_FFFF);
        wait_rx(1, 1'b0);
        chk({16'h0, rx_word}, {16'h0, adc, 2'b00});
        rd(`CDSP_ADDR_CTRL, 32'h0000_0C24);
        chk({29'h0, aux_input_sel, gp_out_bit_eleven, gp_out_bit_ten}, 32'h3);
        wr(`CDSP_ADDR_CTRL, 32'h0000_02E4);
        chk({29'h0, aux_input_sel, gp_out_bit_eleven, gp_out_bit_ten}, 32'h0);
        repeat (40) @(posedge clk_sys);
        rd(`CDSP_ADDR_STATUS, 32'h0000_0009);
        end_of_test();
    end
endmodule
